// [core/led_sink_current_control.v]
// Purpose: current setting, bank mapping, pump gain and ramp control for led sinks
// Assumes: all inputs synchronous to ref_clk; headroom and short comparators are analog
// Notes:   sink levels are 16-bit fractions of the largest current, 0xffff = maximum
//
// The APB interface to the registers and the address map were decided locally.
`include "led_sink_current_control_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module led_sink_current_control (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        hardware_enable_pin,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  pwm_duty,
  input  wire [7:0]  ambient_light_code,
  input  wire [4:0]  lv_headroom_low,
  input  wire        flying_capacitor_present,
  input  wire [1:0]  hv_short_detect,
  input  wire [4:0]  lv_short_detect,
  output reg  [15:0] high_voltage_sink_one_level,
  output reg  [15:0] high_voltage_sink_two_level,
  output reg  [79:0] low_voltage_sink_n_level,
  output reg  [1:0]  boost_feedback_select,
  output reg         boost_freq_500k,
  output reg         pump_output_drive,
  output reg         pump_switching,
  output reg         pump_gain_2x,
  output reg         flying_capacitor_check
);

  localparam [4:0] ST_OFF   = 5'h01;
  localparam [4:0] ST_CHECK = 5'h02;
  localparam [4:0] ST_P1X   = 5'h04;
  localparam [4:0] ST_P2X   = 5'h08;
  localparam [4:0] ST_F1X   = 5'h10;
  // capacitor check length in clock cycles
  localparam integer CAP_CYCLES = `CAP_CHECK_US * `CLK_MHZ;
  localparam [9:0] CAP_LAST = CAP_CYCLES[9:0] - 10'h001;

  // enable pin low acts as a full reset
  wire arst_n = reset_n & hardware_enable_pin;

  reg [5:0]  bank_en_q;
  reg [21:0] bank_cfg_q;
  reg [11:0] sink_map_q;
  reg [6:0]  anode_q;
  reg        freq_q;
  reg [1:0]  pump_mode_q;
  reg [6:0]  ramp_sel_q;
  reg        hv_short_q;
  reg        lv_short_q;
  reg        no_cap_q;
  reg        pump_restart_q;
  reg [7:0]  bright_q [0:5];
  reg [4:0]  fscale_q [0:5];
  reg [7:0]  eff_q    [0:5];
  reg [11:0] cnt_q    [0:5];
  reg [4:0]  pump_st_q;
  reg [9:0]  cap_cnt_q;
  reg [15:0] lvl      [0:5];
  reg [31:0] rdata_d;
  reg        rerr_d;

  // per bank ramp target and step interval
  reg [7:0]  tgt_d    [0:5];
  reg [11:0] lim_d    [0:5];
  integer    b;
  integer    bt;
  integer    br;
  integer    bl;
  integer    bo;

  wire access = psel & penable;
  wire wr     = access & pready & pwrite;
  wire [2:0] widx = paddr[4:2];
  wire page_ok = (paddr[1:0] == 2'h0) && (widx < 3'h6);
  // page decode shared by reads and writes; status decode used by writes only
  wire bright_hit = (paddr[11:5] == `BRIGHT_PAGE) && page_ok;
  wire fscale_hit = (paddr[11:5] == `FSCALE_PAGE) && page_ok;
  wire status_wr  = wr && (paddr == `OFF_STATUS);

  // exponential or linear map, full-scale and duty weighting
  function [15:0] bank_level;
    input [7:0] code;
    input       lin;
    input [4:0] fs;
    input       pwm_en;
    input [7:0] duty;
    reg [7:0]  k;
    reg [13:0] t;
    reg [15:0] m;
    reg [15:0] v;
    reg [21:0] p;
    reg [24:0] q;
    reg [8:0]  w;
    begin
      k = 8'hff - code;
      t = {6'h00, k} * 14'd40;
      // 0.862^(46.6-(code+1)/5.5) is about 2^-((255-code)/25.6)
      m = 16'hffff - {1'b0, t[9:0], 5'h00};
      v = lin ? {code, code} : (m >> t[13:10]);
      p = {6'h00, v} * {16'h0000, {1'b0, fs} + 6'h01};
      // duty 0 gives no current, full duty passes the level unscaled
      w = pwm_en ? ({1'b0, duty} + {8'h00, duty[7]}) : 9'h100;
      q = {9'h000, p[20:5]} * {16'h0000, w};
      bank_level = (code == 8'h00) ? 16'h0000 : q[23:8];
    end
  endfunction

  // cycles per ramp step for a ramp time selection
  function [11:0] ramp_lim;
    input [2:0] s;
    reg [31:0] us;
    reg [31:0] n;
    begin
      case (s)
        3'h0:    us = `RAMP_US_0;
        3'h1:    us = `RAMP_US_1;
        3'h2:    us = `RAMP_US_2;
        3'h3:    us = `RAMP_US_3;
        3'h4:    us = `RAMP_US_4;
        3'h5:    us = `RAMP_US_5;
        3'h6:    us = `RAMP_US_6;
        default: us = `RAMP_US_7;
      endcase
      n = us * `CLK_MHZ / `RAMP_STEPS;
      ramp_lim = (n == 32'h0) ? 12'h001 : n[11:0];
    end
  endfunction

  // apb slave, one wait state on every access
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & rerr_d;
      if (access & ~pready & ~pwrite)
        prdata <= rdata_d;
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    case (paddr)
      `OFF_BANK_ENABLE: rdata_d = {26'h0, bank_en_q};
      `OFF_BANK_CONFIG: rdata_d = {10'h0, bank_cfg_q};
      `OFF_SINK_MAP:    rdata_d = {20'h0, sink_map_q};
      `OFF_ANODE:       rdata_d = {25'h0, anode_q};
      `OFF_PROT_FREQ:   rdata_d = {30'h0, freq_q, 1'b0};
      `OFF_PUMP_MODE:   rdata_d = {30'h0, pump_mode_q};
      `OFF_RAMP_TIME:   rdata_d = {25'h0, ramp_sel_q};
      `OFF_STATUS:      rdata_d = {28'h0, lv_short_q, hv_short_q, no_cap_q, pump_gain_2x};
      default: begin
        if (bright_hit)
          rdata_d = {24'h0, bright_q[widx]};
        else if (fscale_hit)
          rdata_d = {27'h0, fscale_q[widx]};
        else
          rerr_d = 1'b1;
      end
    endcase
  end

  // register writes and sticky fault flags
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_en_q      <= 6'h00;
      bank_cfg_q     <= 22'h000000;
      sink_map_q     <= 12'h000;
      anode_q        <= `RST_ANODE;
      freq_q         <= 1'b0;
      pump_mode_q    <= `RST_PUMP_MODE;
      ramp_sel_q     <= 7'h00;
      hv_short_q     <= 1'b0;
      lv_short_q     <= 1'b0;
      pump_restart_q <= 1'b0;
      for (b = 0; b < `NUM_BANKS; b = b + 1) begin
        bright_q[b] <= 8'h00;
        fscale_q[b] <= `RST_FSCALE;
      end
    end else begin
      pump_restart_q <= wr && (paddr == `OFF_PUMP_MODE);
      if (wr) begin
        case (paddr)
          `OFF_BANK_ENABLE: bank_en_q   <= pwdata[5:0];
          `OFF_BANK_CONFIG: bank_cfg_q  <= pwdata[21:0];
          `OFF_SINK_MAP:    sink_map_q  <= pwdata[11:0];
          `OFF_ANODE:       anode_q     <= pwdata[6:0];
          `OFF_PROT_FREQ:   freq_q      <= pwdata[`FREQ_500K_BIT];
          `OFF_PUMP_MODE:   pump_mode_q <= pwdata[1:0];
          `OFF_RAMP_TIME:   ramp_sel_q  <= pwdata[6:0];
          default: begin
            if (bright_hit)
              bright_q[widx] <= pwdata[7:0];
            if (fscale_hit)
              fscale_q[widx] <= pwdata[4:0];
          end
        endcase
      end
      // write one clears; a new short in the same cycle wins
      if (|(hv_short_detect & anode_q[1:0]))
        hv_short_q <= 1'b1;
      else if (status_wr && pwdata[`STS_HVSHORT_BIT])
        hv_short_q <= 1'b0;
      if (|(lv_short_detect & anode_q[6:2]))
        lv_short_q <= 1'b1;
      else if (status_wr && pwdata[`STS_LVSHORT_BIT])
        lv_short_q <= 1'b0;
    end
  end

  // ramp target per bank; a disabled bank ramps toward zero
  always @* begin
    for (bt = 0; bt < `NUM_BANKS; bt = bt + 1) begin
      tgt_d[bt] = 8'h00;
      if (bank_en_q[bt])
        tgt_d[bt] = bank_cfg_q[`CFG_ALS_LSB + bt] ? ambient_light_code : bright_q[bt];
      // up uses the start-up time, down the shutdown time
      if (tgt_d[bt] > eff_q[bt])
        lim_d[bt] = ramp_lim(ramp_sel_q[2:0]);
      else
        lim_d[bt] = ramp_lim(ramp_sel_q[6:4]);
    end
  end

  // step the effective code one step per interval toward target
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (br = 0; br < `NUM_BANKS; br = br + 1) begin
        eff_q[br] <= 8'h00;
        cnt_q[br] <= 12'h000;
      end
    end else begin
      for (br = 0; br < `NUM_BANKS; br = br + 1) begin
        if (eff_q[br] == tgt_d[br]) begin
          cnt_q[br] <= 12'h000;
        end else if (cnt_q[br] >= lim_d[br] - 12'h001) begin
          cnt_q[br] <= 12'h000;
          if (tgt_d[br] > eff_q[br])
            eff_q[br] <= eff_q[br] + 8'h01;
          else
            eff_q[br] <= eff_q[br] - 8'h01;
        end else begin
          cnt_q[br] <= cnt_q[br] + 12'h001;
        end
      end
    end
  end

  always @* begin
    for (bl = 0; bl < `NUM_BANKS; bl = bl + 1)
      lvl[bl] = bank_level(eff_q[bl], bank_cfg_q[`CFG_LIN_LSB + bl], fscale_q[bl],
                           bank_cfg_q[`CFG_PWM_LSB + bl], pwm_duty);
  end

  // sink outputs follow their assigned bank; lv sinks ignore pump state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_voltage_sink_one_level <= 16'h0000;
      high_voltage_sink_two_level <= 16'h0000;
      low_voltage_sink_n_level    <= 80'h0;
      boost_feedback_select       <= 2'h0;
      boost_freq_500k             <= 1'b0;
    end else begin
      // hv sinks pick bank a or b, lv sinks one of banks c to f
      high_voltage_sink_one_level <= sink_map_q[0] ? lvl[1] : lvl[0];
      high_voltage_sink_two_level <= sink_map_q[1] ? lvl[1] : lvl[0];
      for (bo = 0; bo < 5; bo = bo + 1)
        low_voltage_sink_n_level[16*bo +: 16] <= lvl[2 + sink_map_q[2+2*bo +: 2]];
      // boost loop membership and switching frequency are plain copies
      boost_feedback_select <= anode_q[1:0];
      boost_freq_500k       <= freq_q;
    end
  end

  // pump gain controller; a sink counts toward gain only while lit
  wire [4:0] lv_lit = {|low_voltage_sink_n_level[79:64], |low_voltage_sink_n_level[63:48],
                       |low_voltage_sink_n_level[47:32], |low_voltage_sink_n_level[31:16],
                       |low_voltage_sink_n_level[15:0]};
  wire any_low = |(lv_headroom_low & anode_q[6:2] & lv_lit);
  // a mode write or disable sends the controller back to off
  wire pump_off = pump_restart_q || (pump_mode_q == `PUMP_DISABLED);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_st_q <= ST_OFF;
      cap_cnt_q <= 10'h000;
      no_cap_q  <= 1'b0;
    end else if (pump_off) begin
      pump_st_q <= ST_OFF;
      cap_cnt_q <= 10'h000;
      no_cap_q  <= 1'b0;
    end else begin
      case (pump_st_q)
        ST_OFF: begin
          cap_cnt_q <= 10'h000;
          if (pump_mode_q == `PUMP_AUTO)
            pump_st_q <= ST_CHECK;
          else if (pump_mode_q == `PUMP_FORCE_1X)
            pump_st_q <= ST_F1X;
          else
            pump_st_q <= ST_P2X;
        end
        ST_CHECK: begin
          cap_cnt_q <= cap_cnt_q + 10'h001;
          if (cap_cnt_q == CAP_LAST) begin
            if (flying_capacitor_present) begin
              pump_st_q <= ST_P1X;
            end else begin
              pump_st_q <= ST_F1X;
              no_cap_q  <= 1'b1;
            end
          end
        end
        ST_P1X: begin
          if (any_low)
            pump_st_q <= ST_P2X;
        end
        ST_P2X:  pump_st_q <= ST_P2X;
        ST_F1X:  pump_st_q <= ST_F1X;
        default: pump_st_q <= ST_OFF;
      endcase
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_output_drive      <= 1'b0;
      pump_switching         <= 1'b0;
      pump_gain_2x           <= 1'b0;
      flying_capacitor_check <= 1'b0;
    end else begin
      pump_output_drive      <= (pump_st_q != ST_OFF);
      pump_switching         <= (pump_st_q == ST_P2X) || (pump_st_q == ST_CHECK);
      pump_gain_2x           <= (pump_st_q == ST_P2X);
      flying_capacitor_check <= (pump_st_q == ST_CHECK);
    end
  end

endmodule // led_sink_current_control

`default_nettype wire

// [core/led_sink_current_control_regs.vh]
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 50 MHz ref_clk, 32-bit APB data, one aligned word per register
// Notes:   included by the led sink control core
`ifndef LED_SINK_CURRENT_CONTROL_REGS_VH
`define LED_SINK_CURRENT_CONTROL_REGS_VH

`define CLK_MHZ          50
`define NUM_BANKS        6

// fixed register byte addresses
`define OFF_BANK_ENABLE  12'h000
`define OFF_BANK_CONFIG  12'h004
`define OFF_SINK_MAP     12'h008
`define OFF_ANODE        12'h00c
`define OFF_PROT_FREQ    12'h010
`define OFF_PUMP_MODE    12'h014
`define OFF_RAMP_TIME    12'h018
`define OFF_STATUS       12'h060
// per-bank pages: word index inside the page is the bank number
`define BRIGHT_PAGE      7'h01
`define FSCALE_PAGE      7'h02

// bank configuration fields
`define CFG_LIN_LSB      0
`define CFG_PWM_LSB      8
`define CFG_ALS_LSB      16

// reset values
`define RST_ANODE        7'h7f
`define RST_FSCALE       5'h13
`define RST_PUMP_MODE    2'h0

// field positions
`define FREQ_500K_BIT    1
`define STS_GAIN2X_BIT   0
`define STS_NOCAP_BIT    1
`define STS_HVSHORT_BIT  2
`define STS_LVSHORT_BIT  3

// pump modes
`define PUMP_DISABLED    2'h0
`define PUMP_AUTO        2'h1
`define PUMP_FORCE_1X    2'h2
`define PUMP_FORCE_2X    2'h3

// timing, in microseconds, and ramp step count
`define CAP_CHECK_US     10
`define RAMP_US_0        0
`define RAMP_US_1        262
`define RAMP_US_2        524
`define RAMP_US_3        1049
`define RAMP_US_4        2097
`define RAMP_US_5        4194
`define RAMP_US_6        8389
`define RAMP_US_7        16780
`define RAMP_STEPS       256

`endif

// [tb/led_sink_asserts.sv]
// Purpose: port checks for the led sink control block
// Assumes: bound to led_sink_current_control, one clock domain
// Notes:   either reset input suspends the checks
`timescale 1ns/1ps
`default_nettype none
module led_sink_asserts (
  input wire        ref_clk,
  input wire        reset_n,
  input wire        hardware_enable_pin,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [1:0]  boost_feedback_select,
  input wire        boost_freq_500k,
  input wire        pump_switching,
  input wire        pump_gain_2x,
  input wire        flying_capacitor_check
);
  wire       wr_done = psel && penable && pready && pwrite && !pslverr;
  wire       rst_any = !reset_n || !hardware_enable_pin;
  reg  [3:0] since_mode_q;
  reg  [9:0] check_len_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst_any);
  // cycles since the last pump mode write, saturating
  always @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      since_mode_q <= 4'hf;
      check_len_q  <= 10'h000;
    end else begin
      if (wr_done && paddr == 12'h014)
        since_mode_q <= 4'h0;
      else if (since_mode_q != 4'hf)
        since_mode_q <= since_mode_q + 4'h1;
      check_len_q <= flying_capacitor_check ? check_len_q + 10'h001 : 10'h000;
    end
  end
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_read_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read returned data");
  chk_anode_copy: assert property (
    wr_done && paddr == 12'h00c |-> ##2 boost_feedback_select == $past(pwdata[1:0], 2))
    else $error("boost feedback select does not follow anode write");
  chk_freq_select: assert property (
    wr_done && paddr == 12'h010 |-> ##2 boost_freq_500k == $past(pwdata[1], 2))
    else $error("boost frequency does not follow register bit");
  chk_gain_switches: assert property (pump_gain_2x |-> pump_switching && !flying_capacitor_check)
    else $error("2x gain without switching");
  chk_check_switch: assert property (flying_capacitor_check |-> pump_switching && !pump_gain_2x)
    else $error("capacitor check state inconsistent");
  chk_latch_hold: assert property ($fell(pump_gain_2x) |-> since_mode_q < 4'h8)
    else $error("2x gain dropped without mode reselect");
  chk_check_bound: assert property (check_len_q <= 10'h1fe)
    else $error("capacitor check too long");
endmodule // led_sink_asserts
bind led_sink_current_control led_sink_asserts i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .hardware_enable_pin(hardware_enable_pin),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .boost_feedback_select(boost_feedback_select), .boost_freq_500k(boost_freq_500k),
  .pump_switching(pump_switching), .pump_gain_2x(pump_gain_2x),
  .flying_capacitor_check(flying_capacitor_check));
`default_nettype wire

// [tb/led_sink_current_control_tb_top.sv]
// Purpose: directed tests of the led sink control block
// Assumes: one wait state apb slave, 50 MHz clock
// Notes:   sink levels are judged by relations between settings
`timescale 1ns/1ps
`default_nettype none
module led_sink_current_control_tb_top;
  logic        ref_clk, reset_n, hw_en, psel, penable, pwrite, cap, pready, pslverr, er;
  logic        f500, drv, sw, g2, chk_o;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  duty, amb;
  logic [4:0]  head, lvs;
  logic [1:0]  hvs, fb;
  logic [15:0] hv1, hv2, lin;
  logic [79:0] lv;
  int          n_errors, n_compared;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  led_sink_current_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .hardware_enable_pin(hw_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_duty(duty), .ambient_light_code(amb), .lv_headroom_low(head),
    .flying_capacitor_present(cap), .hv_short_detect(hvs), .lv_short_detect(lvs),
    .high_voltage_sink_one_level(hv1), .high_voltage_sink_two_level(hv2),
    .low_voltage_sink_n_level(lv), .boost_feedback_select(fb), .boost_freq_500k(f500),
    .pump_output_drive(drv), .pump_switching(sw), .pump_gain_2x(g2),
    .flying_capacitor_check(chk_o));
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata; er = pslverr;
    if (pready !== 1'b1) begin n_errors++; results; end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0); check(rd, e);
  endtask
  task wait_check;
    int k;
    k = 0;
    while (chk_o !== 1'b0 && k < 700) begin tick(1); k++; end
    if (chk_o !== 1'b0) begin n_errors++; results; end
    tick(3);
  endtask
  task t_reset;
    rdc(12'h00c, 32'h7f);
    rdc(12'h040, 32'h13);
    rdc(12'h014, 32'h0);
    check({drv, fb}, 3'h3);
    bus(1'b1, 12'h03c, 32'h5); check(er, 1'b1);
    rdc(12'h03c, 32'h0); check(er, 1'b1);
    bus(1'b1, 12'h00c, 32'h0); bus(1'b1, 12'h014, 32'h2);
    hw_en <= 1'b0; tick(2); hw_en <= 1'b1; tick(1);
    rdc(12'h00c, 32'h7f);
    rdc(12'h014, 32'h0);
    bus(1'b1, 12'h010, 32'h2); tick(1); check(f500, 1'b1);
    bus(1'b1, 12'h010, 32'h0); tick(1); check(f500, 1'b0);
    bus(1'b1, 12'h00c, 32'h7d); tick(1); check(fb, 2'h1);
    $display("test reset and registers done");
  endtask
  task t_pump;
    bus(1'b1, 12'h014, 32'h2); tick(6); check({drv, sw, g2}, 3'h4);
    bus(1'b1, 12'h014, 32'h3); tick(6); check({drv, sw, g2}, 3'h7);
    bus(1'b1, 12'h014, 32'h0); tick(6); check({drv, sw, g2}, 3'h0);
    bus(1'b1, 12'h00c, 32'h7f); bus(1'b1, 12'h000, 32'h4); bus(1'b1, 12'h028, 32'h80);
    bus(1'b1, 12'h014, 32'h1); tick(5); check(chk_o, 1'b1);
    wait_check; check({sw, g2}, 2'h0);
    head <= 5'h01; tick(6); check(g2, 1'b1);
    head <= 5'h00; tick(6); check(g2, 1'b1);
    bus(1'b1, 12'h014, 32'h1); tick(6); check(g2, 1'b0);
    wait_check; bus(1'b1, 12'h00c, 32'h7b);
    head <= 5'h01; tick(6); check(g2, 1'b0);
    head <= 5'h00; cap <= 1'b0; bus(1'b1, 12'h014, 32'h1); tick(5);
    wait_check; check(g2, 1'b0);
    bus(1'b0, 12'h060, 32'h0); check(rd & 32'h3, 32'h2);
    cap <= 1'b1; bus(1'b1, 12'h014, 32'h0); bus(1'b1, 12'h060, 32'hf);
    hvs <= 2'h1; lvs <= 5'h01; tick(3); hvs <= 2'h0; lvs <= 5'h00;
    bus(1'b0, 12'h060, 32'h0); check(rd & 32'hc, 32'h4);
    bus(1'b1, 12'h060, 32'hc); bus(1'b0, 12'h060, 32'h0); check(rd & 32'hc, 32'h0);
    $display("test pump and faults done");
  endtask
  task t_level;
    bus(1'b1, 12'h004, 32'h1); bus(1'b1, 12'h020, 32'hff); bus(1'b1, 12'h000, 32'h1);
    tick(300); lin = hv1; check(lin > 16'h0, 1'b1);
    bus(1'b1, 12'h020, 32'h80); tick(300);
    check(hv1 > lin / 3 && hv1 < lin / 3 * 2, 1'b1);
    bus(1'b1, 12'h004, 32'h0); tick(10); check(hv1 < lin / 16, 1'b1);
    bus(1'b1, 12'h020, 32'hff); tick(300); check(hv1 > lin - lin / 8, 1'b1);
    duty <= 8'h00; bus(1'b1, 12'h004, 32'h100); tick(10); check(hv1, 16'h0);
    duty <= 8'hff; bus(1'b1, 12'h004, 32'h10000); tick(300); check(hv1, 16'h0);
    amb <= 8'hff; tick(300); check(hv1 > 16'h0, 1'b1);
    bus(1'b1, 12'h004, 32'h0); bus(1'b1, 12'h000, 32'h0); tick(300);
    check(hv1, 16'h0);
    bus(1'b1, 12'h018, 32'h1); bus(1'b1, 12'h000, 32'h1); tick(100);
    check(hv1 < lin / 64, 1'b1);
    bus(1'b1, 12'h000, 32'h0); tick(10); check(hv1, 16'h0);
    bus(1'b1, 12'h018, 32'h0); bus(1'b1, 12'h008, 32'hc00);
    bus(1'b1, 12'h034, 32'hff); bus(1'b1, 12'h000, 32'h20); tick(300);
    check(lv[79:64] > 16'h0, 1'b1);
    check(|{lv[63:0], hv2}, 1'b0);
    $display("test levels and ramps done");
  endtask
  initial begin
    reset_n = 1'b0; hw_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; duty = 8'hff; amb = 8'h0; head = 5'h0; cap = 1'b1;
    hvs = 2'h0; lvs = 5'h0; n_errors = 0; n_compared = 0;
    tick(12);
    reset_n <= 1'b1;
    tick(1);
    t_reset;
    t_pump;
    t_level;
    results;
  end
endmodule // led_sink_current_control_tb_top
`default_nettype wire
